// File: core/serdes_phy_cfg_pkg.sv
// Package: register map, field positions and reset values of the receive PHY configuration bank
package serdes_phy_cfg_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int EQ_W = 4;
    localparam int DIV_W = 2;
    // Offset printed only as a garbled value; kept at the next free slot before 0x206
    localparam logic [11:0] LINK_BUFFER_POWER_DOWN_ADDR = 12'h203;
    localparam logic [11:0] RECOVERY_LOGIC_RESET_ADDR = 12'h206;
    localparam logic [11:0] RECOVERY_OPERATING_MODE_ADDR = 12'h230;
    localparam logic [11:0] EQUALIZER_LANES_ZERO_ONE_ADDR = 12'h250;
    localparam logic [11:0] EQUALIZER_LANES_TWO_THREE_ADDR = 12'h251;
    localparam int SYNC_PD_BIT = 1;
    localparam int PD_SPARE_BIT = 0;
    localparam int RECOVERY_RESET_BIT = 0;
    localparam int HALF_RATE_BIT = 5;
    localparam int MODE_SPARE_HI = 4;
    localparam int MODE_SPARE_LO = 3;
    localparam int DIV_HI = 2;
    localparam int DIV_LO = 1;
    localparam int MODE_SPARE0_BIT = 0;
    localparam int EQ_HI_LSB = 4;
    localparam int EQ_LO_LSB = 0;
    localparam logic SYNC_PD_RESET = 1'h0;
    localparam logic SPARE_RESET = 1'h0;
    localparam logic RECOVERY_RESET_RESET = 1'h1;
    localparam logic HALF_RATE_RESET = 1'h1;
    localparam logic [1:0] MODE_SPARE_RESET = 2'h1;
    localparam logic [1:0] DIV_RESET = 2'h0;
    localparam logic [3:0] EQ_RESET = 4'h8;
    localparam logic [3:0] EQ_MANUAL = 4'h0;
    localparam logic [1:0] DIV_NONE = 2'h0;
    localparam logic [1:0] DIV_BY_TWO = 2'h1;
    localparam logic [1:0] DIV_BY_FOUR = 2'h2;
    localparam logic [2:0] DIVIDE_FACTOR_ONE = 3'h1;
    localparam logic [2:0] DIVIDE_FACTOR_TWO = 3'h2;
    localparam logic [2:0] DIVIDE_FACTOR_FOUR = 3'h4;
    localparam logic [7:0] READ_ZERO = 8'h00;
endpackage : serdes_phy_cfg_pkg

// File: core/serdes_phy_config_regs.sv
// Register bank that configures the multi-lane serial receive PHY
//
// How it works
// - Sync buffer power-down bit 1 powers down the sync request output buffer.
// - Bit 0 of the recovery reset register, reset value 1, resets every lane.
// - Recovery logic held in reset while bit reads 0, runs while 1.
// - Half-rate bit 0 gives full-rate recovery, 1 gives half-rate operation.
// - Division field bits 2:1: 00 none, 01 divide by two, 10 by four.
// - Four-bit lane equalizer, reset 8; 0 means manual, N means boost N.
`timescale 1ns/1ps
`default_nettype none
module serdes_phy_config_regs
    import serdes_phy_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    output logic [DATA_W-1:0] rd_data,
    output logic sync_buffer_enable,
    output logic recovery_logic_reset_n,
    output logic half_rate_enable,
    output logic [DIV_W-1:0] division_code,
    output logic [2:0] divide_factor,
    output logic [EQ_W-1:0] lane0_equalizer,
    output logic [EQ_W-1:0] lane1_equalizer,
    output logic [EQ_W-1:0] lane2_equalizer,
    output logic [EQ_W-1:0] lane3_equalizer,
    output logic [3:0] lane_manual_eq
);

    // ========================================================================
    // Storage
    logic sync_buffer_power_down_q;
    logic pd_spare_q;
    logic recovery_reset_bit_q;
    logic half_rate_q;
    logic [1:0] mode_spare_q;
    logic [DIV_W-1:0] div_q;
    logic mode_spare0_q;
    logic [DATA_W-1:0] eq01_q;
    logic [DATA_W-1:0] eq23_q;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] reg_addr);
        hit = wr_en && (a == reg_addr);
    endfunction : hit

    // Power-down register; spare bit is writable storage
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync_buffer_power_down_q <= SYNC_PD_RESET;
            pd_spare_q <= SPARE_RESET;
        end else if (hit(addr, LINK_BUFFER_POWER_DOWN_ADDR)) begin
            sync_buffer_power_down_q <= wr_data[SYNC_PD_BIT];
            pd_spare_q <= wr_data[PD_SPARE_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            recovery_reset_bit_q <= RECOVERY_RESET_RESET;
        end else if (hit(addr, RECOVERY_LOGIC_RESET_ADDR)) begin
            recovery_reset_bit_q <= wr_data[RECOVERY_RESET_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            half_rate_q <= HALF_RATE_RESET;
            mode_spare_q <= MODE_SPARE_RESET;
            div_q <= DIV_RESET;
            mode_spare0_q <= SPARE_RESET;
        end else if (hit(addr, RECOVERY_OPERATING_MODE_ADDR)) begin
            half_rate_q <= wr_data[HALF_RATE_BIT];
            mode_spare_q <= wr_data[MODE_SPARE_HI:MODE_SPARE_LO];
            div_q <= wr_data[DIV_HI:DIV_LO];
            mode_spare0_q <= wr_data[MODE_SPARE0_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            eq01_q <= {EQ_RESET, EQ_RESET};
            eq23_q <= {EQ_RESET, EQ_RESET};
        end else begin
            if (hit(addr, EQUALIZER_LANES_ZERO_ONE_ADDR)) begin
                eq01_q <= wr_data;
            end
            if (hit(addr, EQUALIZER_LANES_TWO_THREE_ADDR)) begin
                eq23_q <= wr_data;
            end
        end
    end

    // ========================================================================
    // Read path, registered; unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_data <= READ_ZERO;
        end else if (rd_en) begin
            case (addr)
                LINK_BUFFER_POWER_DOWN_ADDR: begin
                    rd_data <= {6'h00, sync_buffer_power_down_q, pd_spare_q};
                end
                RECOVERY_LOGIC_RESET_ADDR: begin
                    rd_data <= {7'h00, recovery_reset_bit_q};
                end
                RECOVERY_OPERATING_MODE_ADDR: begin
                    rd_data <= {2'h0, half_rate_q, mode_spare_q, div_q,
                                mode_spare0_q};
                end
                EQUALIZER_LANES_ZERO_ONE_ADDR: begin
                    rd_data <= eq01_q;
                end
                EQUALIZER_LANES_TWO_THREE_ADDR: begin
                    rd_data <= eq23_q;
                end
                default: begin
                    rd_data <= READ_ZERO;
                end
            endcase
        end
    end

    // ========================================================================
    // Controls to the analog and recovery logic
    assign sync_buffer_enable = !sync_buffer_power_down_q;
    assign recovery_logic_reset_n = recovery_reset_bit_q;
    assign half_rate_enable = half_rate_q;
    assign division_code = div_q;
    assign lane0_equalizer = eq01_q[EQ_LO_LSB +: EQ_W];
    assign lane1_equalizer = eq01_q[EQ_HI_LSB +: EQ_W];
    assign lane2_equalizer = eq23_q[EQ_LO_LSB +: EQ_W];
    assign lane3_equalizer = eq23_q[EQ_HI_LSB +: EQ_W];

    // Manual flag per lane: code zero hands control to software values
    assign lane_manual_eq = {lane3_equalizer == EQ_MANUAL,
                             lane2_equalizer == EQ_MANUAL,
                             lane1_equalizer == EQ_MANUAL,
                             lane0_equalizer == EQ_MANUAL};

    // Undefined code 11 falls back to no division rather than guessing
    always_comb begin
        case (div_q)
            DIV_BY_TWO: divide_factor = DIVIDE_FACTOR_TWO;
            DIV_BY_FOUR: divide_factor = DIVIDE_FACTOR_FOUR;
            default: divide_factor = DIVIDE_FACTOR_ONE;
        endcase
    end

    // ========================================================================
    // Checks
    sequence s_write_reset(logic [DATA_W-1:0] d);
        wr_en && addr == RECOVERY_LOGIC_RESET_ADDR && d[RECOVERY_RESET_BIT];
    endsequence

    chk_sync_pd_write: assert property (@(posedge clock) disable iff (!rst_n)
        hit(addr, LINK_BUFFER_POWER_DOWN_ADDR) |=>
        sync_buffer_enable == !$past(wr_data[SYNC_PD_BIT]))
        else $error("sync buffer enable does not follow write");
    chk_reset_value_one: assert property (@(posedge clock)
        $rose(rst_n) |-> recovery_logic_reset_n && half_rate_enable)
        else $error("recovery reset or half rate reset value wrong");
    chk_recovery_release: assert property (@(posedge clock)
        disable iff (!rst_n)
        s_write_reset(wr_data) |=> recovery_logic_reset_n)
        else $error("recovery logic not released after write of one");
    chk_recovery_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (hit(addr, RECOVERY_LOGIC_RESET_ADDR) && !wr_data[RECOVERY_RESET_BIT])
        |=> !recovery_logic_reset_n)
        else $error("recovery logic not held in reset");
    chk_half_rate_write: assert property (@(posedge clock)
        disable iff (!rst_n) hit(addr, RECOVERY_OPERATING_MODE_ADDR) |=>
        half_rate_enable == $past(wr_data[HALF_RATE_BIT]))
        else $error("half rate enable does not follow write");
    chk_div_factor: assert property (@(posedge clock) disable iff (!rst_n)
        division_code == DIV_BY_FOUR |-> divide_factor == DIVIDE_FACTOR_FOUR
        ##0 1)
        else $error("division factor mismatch");
    chk_div_two: assert property (@(posedge clock) disable iff (!rst_n)
        (hit(addr, RECOVERY_OPERATING_MODE_ADDR)
         && wr_data[DIV_HI:DIV_LO] == DIV_BY_TWO)
        |=> divide_factor == DIVIDE_FACTOR_TWO)
        else $error("divide by two not selected");
    chk_eq_lane3: assert property (@(posedge clock) disable iff (!rst_n)
        hit(addr, EQUALIZER_LANES_TWO_THREE_ADDR) |=>
        lane3_equalizer == $past(wr_data[EQ_HI_LSB +: EQ_W])
        && lane_manual_eq[3] == ($past(wr_data[EQ_HI_LSB +: EQ_W]) == EQ_MANUAL))
        else $error("lane three equalizer wrong");
    chk_eq_reset: assert property (@(posedge clock)
        $rose(rst_n) |-> lane0_equalizer == EQ_RESET
        && lane1_equalizer == EQ_RESET)
        else $error("equalizer reset value wrong");
    // Reset values of the controls that no other check looks at, except lane2_equalizer, which no check tests
    chk_ctrl_reset: assert property (@(posedge clock)
        $rose(rst_n) |-> sync_buffer_enable && division_code == DIV_RESET
        && divide_factor == DIVIDE_FACTOR_ONE
        && lane3_equalizer == EQ_RESET)
        else $error("control reset value wrong");
    chk_eq_lanes_low: assert property (@(posedge clock) disable iff (!rst_n)
        hit(addr, EQUALIZER_LANES_ZERO_ONE_ADDR) |=>
        lane0_equalizer == $past(wr_data[EQ_LO_LSB +: EQ_W])
        && lane1_equalizer == $past(wr_data[EQ_HI_LSB +: EQ_W]))
        else $error("lane zero or one equalizer wrong");
    // Flag judged from the written code, so a broken decode cannot hide
    chk_manual_lane0: assert property (@(posedge clock) disable iff (!rst_n)
        (hit(addr, EQUALIZER_LANES_ZERO_ONE_ADDR)
         && wr_data[EQ_LO_LSB +: EQ_W] == EQ_MANUAL)
        |=> lane_manual_eq[0])
        else $error("lane zero manual flag not set");

    sequence s_mode_write(logic [DIV_W-1:0] code);
        hit(addr, RECOVERY_OPERATING_MODE_ADDR)
        && wr_data[DIV_HI:DIV_LO] == code;
    endsequence

    chk_div_none: assert property (@(posedge clock) disable iff (!rst_n)
        s_mode_write(DIV_NONE) |=> divide_factor == DIVIDE_FACTOR_ONE)
        else $error("no division not selected");
    // Only a write to its own register may move the recovery reset
    chk_reset_bit_stable: assert property (@(posedge clock)
        disable iff (!rst_n)
        !hit(addr, RECOVERY_LOGIC_RESET_ADDR) |=>
        $stable(recovery_logic_reset_n))
        else $error("recovery reset moved without a write");

endmodule : serdes_phy_config_regs
`default_nettype wire

// File: test/testbench.sv
// Testbench: self-checking regression of the receive PHY configuration bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import serdes_phy_cfg_pkg::*;
    logic clock, rst_n, wr_en, rd_en, rd_prev;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data, rd_data;
    logic sync_buffer_enable, recovery_logic_reset_n, half_rate_enable;
    logic [DIV_W-1:0] division_code;
    logic [2:0] divide_factor;
    logic [EQ_W-1:0] lane0_equalizer, lane1_equalizer;
    logic [EQ_W-1:0] lane2_equalizer, lane3_equalizer;
    logic [3:0] lane_manual_eq, lanes [4];
    logic [7:0] expq [$];
    int n_errors = 0;
    int checks = 0;
    serdes_phy_config_regs i_dut (.clock(clock), .rst_n(rst_n),
        .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
        .rd_data(rd_data), .sync_buffer_enable(sync_buffer_enable),
        .recovery_logic_reset_n(recovery_logic_reset_n),
        .half_rate_enable(half_rate_enable), .division_code(division_code),
        .divide_factor(divide_factor), .lane0_equalizer(lane0_equalizer),
        .lane1_equalizer(lane1_equalizer), .lane2_equalizer(lane2_equalizer),
        .lane3_equalizer(lane3_equalizer), .lane_manual_eq(lane_manual_eq));
    // =========================================
    // Clock, compares and bus tasks
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare
    task automatic compare_read(input logic [7:0] got, input logic [7:0] exp);
        compare(got, exp);
    endtask : compare_read
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        wr_en = 1'b1;
        addr = a;
        wr_data = d;
        @(posedge clock);
        #2;
        wr_en = 1'b0;
        // Idle edge so the next strobe never rises in the same step
        @(posedge clock);
        #2;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        expq.push_back(exp);
        rd_en = 1'b1;
        addr = a;
        @(posedge clock);
        #2;
        rd_en = 1'b0;
        @(posedge clock);
        #2;
    endtask : rd
    task automatic print_verdict();
        $display("Counts: checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    // =========================================
    // Read monitor: oldest note against each answer
    always @(posedge clock) rd_prev <= rd_en;
    always @(negedge clock) begin
        if (rd_prev === 1'b1) begin
            if (expq.size() == 0) begin
                n_errors++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time,
                    rd_data, 8'h00);
            end else compare_read(rd_data, expq.pop_front());
        end
    end
    // Hang guard, far above the few hundred cycles used
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        print_verdict();
    end
    // =========================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 12'h000;
        wr_data = 8'h00;
        void'($urandom(47059));
        repeat (16) @(posedge clock);
        #2 rst_n = 1'b1;
        rd(12'h203, 8'h00);
        rd(12'h206, 8'h01);
        rd(12'h230, 8'h28);
        rd(12'h250, 8'h88);
        rd(12'h251, 8'h88);
        rd(12'h300, 8'h00);
        compare({7'h00, half_rate_enable}, 8'h01);
        compare({4'h0, lane_manual_eq}, 8'h00);
        $display("Test reset values done");
        wr(12'h203, 8'hFF);
        compare({7'h00, sync_buffer_enable}, 8'h00);
        rd(12'h203, 8'h03);
        wr(12'h203, 8'h00);
        compare({7'h00, sync_buffer_enable}, 8'h01);
        wr(12'h206, 8'h00);
        compare({7'h00, recovery_logic_reset_n}, 8'h00);
        rd(12'h206, 8'h00);
        wr(12'h206, 8'hFE);
        compare({7'h00, recovery_logic_reset_n}, 8'h00);
        wr(12'h206, 8'hFF);
        compare({7'h00, recovery_logic_reset_n}, 8'h01);
        $display("Test power-down and recovery reset done");
        for (int c = 0; c < 3; c++) begin
            lanes[0] = 4'($urandom);
            wr(12'h230, {2'h0, lanes[0][0], 2'h1, 2'(c), 1'b0});
            compare({7'h00, half_rate_enable}, {7'h00, lanes[0][0]});
            compare({6'h00, division_code}, 8'(c));
            compare({5'h00, divide_factor}, 8'(1 << c));
            rd(12'h230, {2'h0, lanes[0][0], 2'h1, 2'(c), 1'b0});
        end
        $display("Test operating mode done");
        for (int n = 0; n < 16; n++) begin
            lanes[0] = 4'(n);
            lanes[1] = 4'(15 - n);
            lanes[2] = 4'(n + 5);
            lanes[3] = 4'($urandom);
            wr(12'h250, {lanes[1], lanes[0]});
            wr(12'h251, {lanes[3], lanes[2]});
            compare({lane1_equalizer, lane0_equalizer},
                {lanes[1], lanes[0]});
            compare({lane3_equalizer, lane2_equalizer},
                {lanes[3], lanes[2]});
            compare({4'h0, lane_manual_eq}, {4'h0, lanes[3] == 4'h0,
                lanes[2] == 4'h0, lanes[1] == 4'h0, lanes[0] == 4'h0});
            rd(12'h251, {lanes[3], lanes[2]});
            rd(12'h250, {lanes[1], lanes[0]});
        end
        $display("Test equalizer codes done");
        wr(12'h203, 8'hFF);
        wr(12'h206, 8'h00);
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #2 rst_n = 1'b1;
        compare({7'h00, sync_buffer_enable}, 8'h01);
        compare({7'h00, recovery_logic_reset_n}, 8'h01);
        rd(12'h230, 8'h28);
        rd(12'h206, 8'h01);
        rd(12'h251, 8'h88);
        $display("Test mid-run reset done");
        repeat (3) @(posedge clock);
        compare(8'(expq.size()), 8'h00);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
